// ===== design/dcz_pkg.sv
/*
 * dcz_pkg: register map, field positions, reset values and enums
 * shared by the converter control-register block and its helpers.
 * Assumes one 50 MHz clock and a word-level control port fed by an
 * external serial deserialiser on the same clock.
 */
package dcz_pkg;
    // ------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------
    localparam int      WORD_W       = 16;
    localparam int      DIR_BIT      = 15;
    localparam int      IDX_LSB      = 8;
    localparam int      IDX_W        = 7;
    localparam int      DATA_W       = 8;
    localparam logic    DIR_WRITE    = 1'b0;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [6:0] IDX_SILENCE_LO = 7'h07;
    localparam logic [6:0] IDX_IDLE_LO    = 7'h08;
    localparam logic [6:0] IDX_PHASE      = 7'h0a;
    localparam logic [6:0] IDX_READ_CTL   = 7'h0b;
    localparam logic [6:0] IDX_USER_OSR   = 7'h0c;
    localparam logic [6:0] IDX_SILENCE_HI = 7'h12;
    localparam logic [6:0] IDX_IDLE_HI    = 7'h13;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int      FLAG_INV_BIT  = 6;
    localparam int      PHASE_INV_BIT = 5;
    localparam int      AUTO_STEP_BIT = 7;
    localparam int      OSR_BIT       = 7;
    localparam int      USER_SEL_BIT  = 6;
    localparam int      USER_W        = 6;
    localparam int      LO_CH         = 6;
    localparam int      HI_CH         = 2;
    localparam int      NUM_CH        = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [6:0] READ_LIMIT_RST = 7'h01;
    localparam logic [7:0] BYTE_RST       = 8'h00;

    // ------------------------------------------------------------
    // zero detection and attenuator
    // ------------------------------------------------------------
    localparam int         ZERO_RUN    = 1024;
    localparam int         SAMPLE_W    = 24;
    localparam int         ATT_W       = 8;
    localparam logic [7:0] ATT_MUTE    = 8'h00;

    typedef enum logic [1:0] {
        DCZ_OSR_32X  = 2'b00,
        DCZ_OSR_64X  = 2'b01,
        DCZ_OSR_128X = 2'b10
    } dcz_osr_t;

    typedef enum logic [0:0] {
        DCZ_RD_IDLE = 1'b0,
        DCZ_RD_SEQ  = 1'b1
    } dcz_rd_state_t;
endpackage : dcz_pkg

// ===== design/dcz_zero_det.sv
/*
 * dcz_zero_det: zero-run detector for one channel.
 * Assumes frame_tick is a one-cycle pulse per frame sync period and
 * sample strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dcz_zero_det
    import dcz_pkg::*;
#(
    parameter int RUN = ZERO_RUN
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                frame_tick,
    input  wire logic                smp_valid,
    input  wire logic [SAMPLE_W-1:0] smp_data,
    output logic                     zero_q
);
    localparam int CW = $clog2(RUN + 1);

    if (RUN < 2) begin : g_bad_run
        $error("zero run too short");
    end

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          zero_d;

    always_comb begin
        cnt_d  = cnt_q;
        zero_d = zero_q;
        if (smp_valid && (smp_data != '0)) begin
            cnt_d  = '0;
            zero_d = 1'b0;
        end else if (frame_tick && !zero_q) begin
            cnt_d  = cnt_q + CW'(1);
            zero_d = (cnt_d == CW'(RUN));
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q  <= '0;
            zero_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            zero_q <= zero_d;
        end
    end
endmodule : dcz_zero_det
`default_nettype wire

// ===== design/dcz_silence_step.sv
/*
 * dcz_silence_step: soft-silence ramp of one channel attenuator.
 * Assumes step_tick is a one-cycle pulse per frame; each step is 0.5 dB.
 */
`timescale 1ns/1ps
`default_nettype none
module dcz_silence_step
    import dcz_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             step_tick,
    input  wire logic             silence,
    input  wire logic [ATT_W-1:0] level,
    output logic      [ATT_W-1:0] att_q
);
    logic [ATT_W-1:0] att_d;
    logic [ATT_W-1:0] goal;

    always_comb begin
        goal  = silence ? ATT_MUTE : level;
        att_d = att_q;
        if (step_tick && (att_q > goal)) begin
            att_d = att_q - ATT_W'(1);
        end else if (step_tick && (att_q < goal)) begin
            att_d = att_q + ATT_W'(1);
        end
    end

    // starts at 0 dB; a lower level is reached by the ramp
    always_ff @(posedge clk) begin
        if (!nrst) begin
            att_q <= '1;
        end else begin
            att_q <= att_d;
        end
    end
endmodule : dcz_silence_step
`default_nettype wire

// ===== design/dcz_ctrl.sv
/*
 * dcz_ctrl: control registers, read sequencing and zero flags of an
 * eight-channel audio converter.
 * Assumes a serial deserialiser on clk delivers whole 16-bit control
 * words and takes read words back; frame sync arrives on a pin.
 */
// Behaviour
// - phase invert bit set inverts output phase; clear is normal.
// - flag invert 0 drives zero flags high on detect, 1 low.
// - word bit 15 selects write (0) or read (1).
// - auto step bit enables incrementing multi-register reads; reset 0.
// - single read returns register named by limit field, reset one.
// - auto step read ends at the register named by limit field.
// - user select 1 puts six user bits on shared flag pins.
// - user select 0 puts zero flags of channels 1-6 on pins.
// - high clock ratios: oversample bit gives 64x or 128x.
// - low clock ratios: oversample bit gives 32x or 64x.
// - silence bit ramps attenuator down 0.5 dB steps to mute.
// - clearing silence ramps back up to programmed level.
// - idle select 1 ties amplifier to common mode for ch7/8.
// - each channel detects zero independently.
// - zero detect after 1024 zero frame periods.
// - detected channel asserts own zero flag pin.
// - all-zero flag is AND of eight channel flags.
// - channels 1-6 silence and idle bits behave the same.
`timescale 1ns/1ps
`default_nettype none
module dcz_ctrl
    import dcz_pkg::*;
#(
    parameter int RUN = ZERO_RUN
) (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    // control word port
    input  wire logic                      ctl_valid,
    input  wire logic [WORD_W-1:0]         ctl_word,
    input  wire logic                      rd_next,
    output logic                           rd_valid_q,
    output logic      [WORD_W-1:0]         rd_word_q,
    output logic                           rd_busy,
    // audio side
    input  wire logic                      frame_sync_clock,
    input  wire logic                      smp_valid,
    input  wire logic [2:0]                smp_ch,
    input  wire logic [SAMPLE_W-1:0]       smp_data,
    input  wire logic                      clk_ratio_low,
    input  wire logic [NUM_CH*ATT_W-1:0]   att_level,
    // converter controls
    output logic                           output_phase_invert,
    output dcz_osr_t                       osr_rate,
    output logic      [NUM_CH-1:0]         channel_idle_select,
    output logic      [NUM_CH*ATT_W-1:0]   att_out,
    // flag pins
    output logic      [USER_W-1:0]         zero_flag_pin,
    output logic      [1:0]                zero_flag_pin_hi,
    output logic                           all_zero_flag
);
    if (RUN < 2) begin : g_bad_run
        $error("zero run too short");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [LO_CH-1:0]  silence_lo_q, silence_lo_d;
    logic [LO_CH-1:0]  idle_lo_q, idle_lo_d;
    logic [HI_CH-1:0]  silence_hi_q, silence_hi_d;
    logic [HI_CH-1:0]  idle_hi_q, idle_hi_d;
    logic              phase_inv_q, phase_inv_d;
    logic              flag_polarity_invert_q, flag_polarity_invert_d;
    logic              auto_step_q, auto_step_d;
    logic [IDX_W-1:0]  read_limit_q, read_limit_d;
    logic              osr_q, osr_d;
    logic              user_output_select_q, user_output_select_d;
    logic [USER_W-1:0] user_output_bit_q, user_output_bit_d;

    logic              wr_en;
    logic              rd_en;
    logic [IDX_W-1:0]  cmd_idx;
    logic [DATA_W-1:0] cmd_data;

    assign wr_en    = ctl_valid && (ctl_word[DIR_BIT] == DIR_WRITE);
    assign rd_en    = ctl_valid && (ctl_word[DIR_BIT] != DIR_WRITE);
    assign cmd_idx  = ctl_word[IDX_LSB +: IDX_W];
    assign cmd_data = ctl_word[DATA_W-1:0];

    always_comb begin
        silence_lo_d           = silence_lo_q;
        idle_lo_d              = idle_lo_q;
        silence_hi_d           = silence_hi_q;
        idle_hi_d              = idle_hi_q;
        phase_inv_d            = phase_inv_q;
        flag_polarity_invert_d = flag_polarity_invert_q;
        auto_step_d            = auto_step_q;
        read_limit_d           = read_limit_q;
        osr_d                  = osr_q;
        user_output_select_d   = user_output_select_q;
        user_output_bit_d      = user_output_bit_q;
        if (wr_en) begin
            unique case (cmd_idx)
                IDX_SILENCE_LO: silence_lo_d = cmd_data[LO_CH-1:0];
                IDX_IDLE_LO:    idle_lo_d    = cmd_data[LO_CH-1:0];
                IDX_PHASE: begin
                    phase_inv_d            = cmd_data[PHASE_INV_BIT];
                    flag_polarity_invert_d = cmd_data[FLAG_INV_BIT];
                end
                IDX_READ_CTL: begin
                    auto_step_d  = cmd_data[AUTO_STEP_BIT];
                    read_limit_d = cmd_data[IDX_W-1:0];
                end
                IDX_USER_OSR: begin
                    osr_d                = cmd_data[OSR_BIT];
                    user_output_select_d = cmd_data[USER_SEL_BIT];
                    user_output_bit_d    = cmd_data[USER_W-1:0];
                end
                IDX_SILENCE_HI: silence_hi_d = cmd_data[HI_CH-1:0];
                IDX_IDLE_HI:    idle_hi_d    = cmd_data[HI_CH-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            silence_lo_q           <= '0;
            idle_lo_q              <= '0;
            silence_hi_q           <= '0;
            idle_hi_q              <= '0;
            phase_inv_q            <= 1'b0;
            flag_polarity_invert_q <= 1'b0;
            auto_step_q            <= 1'b0;
            read_limit_q           <= READ_LIMIT_RST;
            osr_q                  <= 1'b0;
            user_output_select_q   <= 1'b0;
            user_output_bit_q      <= '0;
        end else begin
            silence_lo_q           <= silence_lo_d;
            idle_lo_q              <= idle_lo_d;
            silence_hi_q           <= silence_hi_d;
            idle_hi_q              <= idle_hi_d;
            phase_inv_q            <= phase_inv_d;
            flag_polarity_invert_q <= flag_polarity_invert_d;
            auto_step_q            <= auto_step_d;
            read_limit_q           <= read_limit_d;
            osr_q                  <= osr_d;
            user_output_select_q   <= user_output_select_d;
            user_output_bit_q      <= user_output_bit_d;
        end
    end

    // ------------------------------------------------------------
    // read-back
    // ------------------------------------------------------------
    // reads see the stored value; unmapped and reserved bits are zero
    function automatic logic [DATA_W-1:0] reg_byte(input logic [IDX_W-1:0] idx);
        logic [DATA_W-1:0] v;
        v = BYTE_RST;
        unique case (idx)
            IDX_SILENCE_LO: v[LO_CH-1:0] = silence_lo_q;
            IDX_IDLE_LO:    v[LO_CH-1:0] = idle_lo_q;
            IDX_PHASE: begin
                v[PHASE_INV_BIT] = phase_inv_q;
                v[FLAG_INV_BIT]  = flag_polarity_invert_q;
            end
            IDX_READ_CTL: begin
                v[AUTO_STEP_BIT] = auto_step_q;
                v[IDX_W-1:0]     = read_limit_q;
            end
            IDX_USER_OSR: begin
                v[OSR_BIT]      = osr_q;
                v[USER_SEL_BIT] = user_output_select_q;
                v[USER_W-1:0]   = user_output_bit_q;
            end
            IDX_SILENCE_HI: v[HI_CH-1:0] = silence_hi_q;
            IDX_IDLE_HI:    v[HI_CH-1:0] = idle_hi_q;
            default: ;
        endcase
        return v;
    endfunction : reg_byte

    dcz_rd_state_t    rd_st_q, rd_st_d;
    logic [IDX_W-1:0] rd_ptr_q, rd_ptr_d;
    logic             rd_valid_d;
    logic [WORD_W-1:0] rd_word_d;

    assign rd_busy = (rd_st_q == DCZ_RD_SEQ) || rd_valid_q;

    always_comb begin
        rd_st_d    = rd_st_q;
        rd_ptr_d   = rd_ptr_q;
        rd_valid_d = 1'b0;
        rd_word_d  = rd_word_q;
        unique case (rd_st_q)
            DCZ_RD_IDLE: begin
                if (rd_en) begin
                    rd_valid_d = 1'b1;
                    if (auto_step_q && (cmd_idx < read_limit_q)) begin
                        // auto step starts at command index
                        rd_word_d = {1'b0, cmd_idx, reg_byte(cmd_idx)};
                        rd_ptr_d  = cmd_idx + IDX_W'(1);
                        rd_st_d   = DCZ_RD_SEQ;
                    end else if (auto_step_q) begin
                        rd_word_d = {1'b0, cmd_idx, reg_byte(cmd_idx)};
                    end else begin
                        rd_word_d = {1'b0, read_limit_q, reg_byte(read_limit_q)};
                    end
                end
            end
            DCZ_RD_SEQ: begin
                if (rd_next) begin
                    rd_valid_d = 1'b1;
                    rd_word_d  = {1'b0, rd_ptr_q, reg_byte(rd_ptr_q)};
                    rd_ptr_d   = rd_ptr_q + IDX_W'(1);
                    if (rd_ptr_q >= read_limit_q) begin
                        rd_st_d = DCZ_RD_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_st_q    <= DCZ_RD_IDLE;
            rd_ptr_q   <= '0;
            rd_valid_q <= 1'b0;
            rd_word_q  <= '0;
        end else begin
            rd_st_q    <= rd_st_d;
            rd_ptr_q   <= rd_ptr_d;
            rd_valid_q <= rd_valid_d;
            rd_word_q  <= rd_word_d;
        end
    end

    // ------------------------------------------------------------
    // frame sync: two-stage sync and rising edge
    // ------------------------------------------------------------
    logic fs_meta_q, fs_sync_q, fs_prev_q;
    logic frame_tick;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fs_meta_q <= 1'b0;
            fs_sync_q <= 1'b0;
            fs_prev_q <= 1'b0;
        end else begin
            fs_meta_q <= frame_sync_clock;
            fs_sync_q <= fs_meta_q;
            fs_prev_q <= fs_sync_q;
        end
    end

    assign frame_tick = fs_sync_q && !fs_prev_q;

    // ------------------------------------------------------------
    // per-channel zero detect and soft silence
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] zero_det;
    logic [NUM_CH-1:0] silence_all;

    assign silence_all = {silence_hi_q, silence_lo_q};

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        dcz_zero_det #(
            .RUN(RUN)
        ) u_zero (
            .clk       (clk),
            .nrst      (nrst),
            .frame_tick(frame_tick),
            .smp_valid (smp_valid && (smp_ch == 3'(ch))),
            .smp_data  (smp_data),
            .zero_q    (zero_det[ch])
        );

        dcz_silence_step u_silence (
            .clk      (clk),
            .nrst     (nrst),
            .step_tick(frame_tick),
            .silence  (silence_all[ch]),
            .level    (att_level[ch*ATT_W +: ATT_W]),
            .att_q    (att_out[ch*ATT_W +: ATT_W])
        );
    end

    // ------------------------------------------------------------
    // converter controls and flag pins
    // ------------------------------------------------------------
    // phase control output
    assign output_phase_invert = phase_inv_q;

    assign channel_idle_select = {idle_hi_q, idle_lo_q};

    always_comb begin
        if (clk_ratio_low) begin
            osr_rate = osr_q ? DCZ_OSR_64X : DCZ_OSR_32X;
        end else begin
            osr_rate = osr_q ? DCZ_OSR_128X : DCZ_OSR_64X;
        end
    end

    // pins pass through flops so a flag never glitches mid-update
    logic [USER_W-1:0] pin_lo_q, pin_lo_d;
    logic [1:0]        pin_hi_q, pin_hi_d;
    logic              pin_all_q, pin_all_d;

    always_comb begin
        pin_hi_d = zero_det[NUM_CH-1:LO_CH] ^ {HI_CH{flag_polarity_invert_q}};
        pin_all_d = (&zero_det) ^ flag_polarity_invert_q;
        if (user_output_select_q) begin
            pin_lo_d = user_output_bit_q;
        end else begin
            pin_lo_d = zero_det[USER_W-1:0] ^ {USER_W{flag_polarity_invert_q}};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_lo_q  <= '0;
            pin_hi_q  <= '0;
            pin_all_q <= 1'b0;
        end else begin
            pin_lo_q  <= pin_lo_d;
            pin_hi_q  <= pin_hi_d;
            pin_all_q <= pin_all_d;
        end
    end

    assign zero_flag_pin    = pin_lo_q;
    assign zero_flag_pin_hi = pin_hi_q;
    assign all_zero_flag    = pin_all_q;
endmodule : dcz_ctrl
`default_nettype wire

// ===== sim/dcz_ctrl_chk.sv
/* dcz_ctrl_chk: port assertions for dcz_ctrl.
   assumes a bind onto dcz_ctrl and its single clock. */
`timescale 1ns/1ps
`default_nettype none
module dcz_ctrl_chk
    import dcz_pkg::*;
#(
    parameter int RUN = ZERO_RUN
) (
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire logic                    ctl_valid,
    input wire logic [WORD_W-1:0]       ctl_word,
    input wire logic                    rd_next,
    input wire logic                    rd_valid_q,
    input wire logic                    rd_busy,
    input wire logic                    clk_ratio_low,
    input wire logic                    output_phase_invert,
    input wire dcz_osr_t                osr_rate,
    input wire logic [NUM_CH-1:0]       channel_idle_select,
    input wire logic [NUM_CH*ATT_W-1:0] att_out,
    input wire logic [USER_W-1:0]       zero_flag_pin
);
    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic wr;
    assign wr = ctl_valid && !ctl_word[DIR_BIT];
    a_read_gets_answer: assert property (ctl_valid && ctl_word[DIR_BIT] && !rd_busy |=> rd_valid_q)
        else $error("idle read not answered");
    a_write_stays_silent: assert property (wr && !rd_busy && !rd_next |=> !rd_valid_q)
        else $error("write produced a read word");
    a_stray_next_ignored: assert property (rd_next && !rd_busy && !ctl_valid |=> !rd_valid_q)
        else $error("step outside a sequence answered");
    a_phase_follows_write: assert property (wr && ctl_word[14:8] == IDX_PHASE
        |=> output_phase_invert == $past(ctl_word[PHASE_INV_BIT]))
        else $error("phase invert not taken from write");
    a_idle_follows_write: assert property (wr && ctl_word[14:8] == IDX_IDLE_HI
        |=> channel_idle_select[7:6] == $past(ctl_word[1:0]))
        else $error("idle select not taken from write");
    a_user_bits_on_pins: assert property (wr && ctl_word[14:8] == IDX_USER_OSR
        && ctl_word[USER_SEL_BIT] ##1 !(wr && ctl_word[14:8] == IDX_USER_OSR)
        |=> zero_flag_pin == $past(ctl_word[5:0], 2))
        else $error("user bits missing from flag pins");
    a_osr_ratio_map: assert property (
        osr_rate == (clk_ratio_low ? DCZ_OSR_32X : DCZ_OSR_64X)
        || osr_rate == (clk_ratio_low ? DCZ_OSR_64X : DCZ_OSR_128X))
        else $error("oversample rate outside ratio set");
    a_att7_single_step: assert property (
        8'(att_out[55:48] - $past(att_out[55:48])) inside {8'h00, 8'h01, 8'hff})
        else $error("channel 7 attenuator jumped");
    a_att1_single_step: assert property (
        8'(att_out[7:0] - $past(att_out[7:0])) inside {8'h00, 8'h01, 8'hff})
        else $error("channel 1 attenuator jumped");
endmodule : dcz_ctrl_chk
bind dcz_ctrl dcz_ctrl_chk #(.RUN(RUN)) u_chk (.clk(clk), .nrst(nrst), .ctl_valid(ctl_valid),
    .ctl_word(ctl_word), .rd_next(rd_next), .rd_valid_q(rd_valid_q), .rd_busy(rd_busy),
    .clk_ratio_low(clk_ratio_low), .output_phase_invert(output_phase_invert),
    .osr_rate(osr_rate), .channel_idle_select(channel_idle_select), .att_out(att_out),
    .zero_flag_pin(zero_flag_pin));
`default_nettype wire

// ===== sim/dcz_host.sv
/* dcz_host: host model on the control word port.
   assumes the bench calls its tasks; drives at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module dcz_host
    import dcz_pkg::*;
(
    input  wire logic              clk,
    output var logic               ctl_valid,
    output var logic [WORD_W-1:0]  ctl_word,
    output var logic               rd_next
);
    // ------------------------------------------------------------
    // word and step requests
    // ------------------------------------------------------------
    initial begin
        ctl_valid = 1'b0;
        ctl_word  = 16'h0000;
        rd_next   = 1'b0;
    end
    task automatic send(input logic rd, input logic [6:0] idx, input logic [7:0] dat);
        @(negedge clk);
        ctl_valid = 1'b1;
        ctl_word  = {rd, idx, dat};
        @(negedge clk);
        ctl_valid = 1'b0;
        // released word must not look valid
        ctl_word  = ~ctl_word;
    endtask : send
    task automatic step();
        @(negedge clk);
        rd_next = 1'b1;
        @(negedge clk);
        rd_next = 1'b0;
    endtask : step
endmodule : dcz_host
`default_nettype wire

// ===== sim/testbench.sv
/* testbench: self-checking bench for dcz_ctrl with a host model.
   assumes RUN shortened to 4 and an 8-clock frame sync. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dcz_pkg::*;
    logic                    clk, nrst, smp_valid, ratio, ctl_valid, rd_next;
    logic                    rd_valid_q, rd_busy, oph, azf;
    logic [2:0]              smp_ch, fc;
    logic [SAMPLE_W-1:0]     smp_data;
    logic [NUM_CH*ATT_W-1:0] lvl, att;
    logic [WORD_W-1:0]       ctl_word, rd_word_q;
    dcz_osr_t                osr;
    logic [NUM_CH-1:0]       idle;
    logic [USER_W-1:0]       zfp;
    logic [1:0]              zfh;
    logic [7:0]              r;
    logic [15:0]             expq[$];
    int                      n_errors = 0;
    int                      n_compared = 0;
    dcz_ctrl #(.RUN(4)) u_dut (.clk(clk), .nrst(nrst), .ctl_valid(ctl_valid),
        .ctl_word(ctl_word), .rd_next(rd_next), .rd_valid_q(rd_valid_q),
        .rd_word_q(rd_word_q), .rd_busy(rd_busy), .frame_sync_clock(fc[2]),
        .smp_valid(smp_valid), .smp_ch(smp_ch), .smp_data(smp_data), .clk_ratio_low(ratio),
        .att_level(lvl), .output_phase_invert(oph), .osr_rate(osr),
        .channel_idle_select(idle), .att_out(att), .zero_flag_pin(zfp),
        .zero_flag_pin_hi(zfh), .all_zero_flag(azf));
    dcz_host u_host (.clk(clk), .ctl_valid(ctl_valid), .ctl_word(ctl_word), .rd_next(rd_next));
    // ------------------------------------------------------------
    // clock, frame sync, checking
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        fc  = 3'h0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) fc <= fc + 3'h1;
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wait_idle();
        for (int i = 0; i < 30 && rd_busy !== 1'b0; i++) @(negedge clk);
        if (rd_busy !== 1'b0) begin
            n_errors++;
            report_and_stop();
        end
    endtask : wait_idle
    always @(negedge clk) begin
        if (rd_valid_q === 1'b1) begin
            if (expq.size() == 0) check("rd_extra", 16'h0000, 16'h0001);
            else check("rd_word", rd_word_q, expq.pop_front());
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        smp_valid = 1'b0;
        smp_ch = 3'h0;
        smp_data = 24'h000000;
        ratio = 1'b0;
        lvl = {NUM_CH{8'hff}};
        r = 8'($urandom(3));
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        check("att_rst", 16'(att == {NUM_CH{8'hff}}), 16'h0001);
        check("idle_rst", 16'(idle), 16'h0000);
        check("osr_rst", 16'(osr), 16'(DCZ_OSR_64X));
        expq.push_back({1'b0, READ_LIMIT_RST, 8'h00});
        u_host.send(1'b1, 7'h05, 8'h5a);
        wait_idle();
        u_host.send(1'b0, IDX_READ_CTL, 8'h0c);
        for (int k = 0; k < 4; k++) begin
            ratio = k[1];
            r = 8'($urandom);
            r[OSR_BIT] = k[0];
            r[USER_SEL_BIT] = k[1];
            u_host.send(1'b0, IDX_USER_OSR, r);
            check("osr", 16'(osr), 16'(ratio ? (k[0] ? DCZ_OSR_64X : DCZ_OSR_32X)
                : (k[0] ? DCZ_OSR_128X : DCZ_OSR_64X)));
            @(negedge clk);
            if (r[USER_SEL_BIT]) check("user", 16'(zfp), 16'(r[5:0]));
            expq.push_back({1'b0, IDX_USER_OSR, r});
            u_host.send(1'b1, 7'h00, 8'h00);
            wait_idle();
        end
        u_host.send(1'b0, IDX_USER_OSR, 8'h80);
        u_host.send(1'b0, IDX_IDLE_HI, 8'hfe);
        u_host.send(1'b0, IDX_IDLE_LO, 8'hd5);
        check("idle", 16'(idle), 16'h0095);
        u_host.send(1'b0, IDX_READ_CTL, {1'b1, IDX_IDLE_HI});
        u_host.step();
        for (int i = 11; i <= 19; i++)
            expq.push_back({1'b0, 7'(i), i == 11 ? 8'h93 : (i == 19 ? 8'h02
                : (i == 12 ? 8'h80 : 8'h00))});
        u_host.send(1'b1, IDX_READ_CTL, 8'h00);
        repeat (8) u_host.step();
        wait_idle();
        check("queue", 16'(expq.size()), 16'h0000);
        u_host.send(1'b0, IDX_PHASE, 8'h20);
        check("phase", 16'(oph), 16'h0001);
        repeat (80) @(negedge clk);
        check("zero_lo", 16'(zfp), 16'h003f);
        check("zero_hi", 16'(zfh), 16'h0003);
        check("all_zero", 16'(azf), 16'h0001);
        smp_valid = 1'b1;
        smp_ch = 3'h1;
        smp_data = 24'($urandom) | 24'h000001;
        @(negedge clk);
        smp_valid = 1'b0;
        repeat (2) @(negedge clk);
        check("zero_clr", 16'(zfp), 16'h003d);
        check("all_clr", 16'(azf), 16'h0000);
        u_host.send(1'b0, IDX_PHASE, 8'h40);
        repeat (2) @(negedge clk);
        check("inv_lo", 16'(zfp), 16'h0002);
        check("inv_hi", 16'(zfh), 16'h0000);
        check("phase0", 16'(oph), 16'h0000);
        u_host.send(1'b0, IDX_SILENCE_HI, 8'h01);
        u_host.send(1'b0, IDX_SILENCE_LO, 8'h01);
        repeat (40) @(negedge clk);
        check("att7", 16'(att[55:48] inside {[8'hf5:8'hfe]}), 16'h0001);
        check("att1", 16'(att[7:0] inside {[8'hf5:8'hfe]}), 16'h0001);
        check("att2", 16'(att[15:8]), 16'h00ff);
        u_host.send(1'b0, IDX_SILENCE_HI, 8'h00);
        u_host.send(1'b0, IDX_SILENCE_LO, 8'h00);
        repeat (120) @(negedge clk);
        check("att7_back", 16'(att[55:48]), 16'h00ff);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
